// ---- src/fwsr_ctrl.sv ----
/*
 * Flash write-status polling controller: AXI4-Lite registers, toggle and complement polling,
 * failure handling with the reset command. Assumes the flash bus pins and ready/busy pin are
 * asynchronous to i_clk; ready/busy has an external pull-up.
 */
`timescale 1ns/1ns
// Contract
// - poll reads present programmed address
// - erase poll reads address selected sector
// - recheck poll bit when limit flag set
// - two reads compared; unchanged means done
// - toggling with limit flag: recheck, then reset
// - returning host restarts from first double read
// - after timing failure host issues reset
// - reset command is F0 to any address
// - status reads address the busy bank
module fwsr_ctrl #(
	parameter int ACC_CYC = fwsr_pkg::ACCESS_CYC,
	parameter int WP_CYC = fwsr_pkg::WRITE_PULSE_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [fwsr_pkg::AXI_AW-1:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [fwsr_pkg::AXI_AW-1:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output fwsr_pkg::fwsr_pins_s o_flash,
	input wire logic [fwsr_pkg::DATA_W-1:0] i_dq,
	input wire logic i_ready_busy_n_out
);
	import fwsr_pkg::*;

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_strb

	function automatic logic bit_moved(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
		input int pos);
		return a[pos] ^ b[pos];
	endfunction : bit_moved

	fwsr_state_e state;
	fwsr_cyc_s cyc;
	logic bus_busy;
	logic bus_ack;
	logic [DATA_W-1:0] bus_rdata;
	logic aw_held;
	logic w_held;
	logic [AXI_AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [ADDR_W-1:0] poll_addr;
	logic [DATA_W-1:0] expect_word;
	logic mode_poll;
	logic done;
	logic fail;
	logic sect_tog;
	logic [DATA_W-1:0] prev_word;
	logic [DATA_W-1:0] last_word;
	logic rdy_meta;
	logic rdy_sync;
	logic [1:0] rd_cnt;
	logic wr_fire;
	logic ctrl_hit;
	logic go_start;
	logic go_reset;
	logic go_abort;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic toggled;
	logic poll_match;
	logic limit_hit;

	fwsr_bus_cycle #(
		.ACC_CYC(ACC_CYC),
		.WP_CYC(WP_CYC)
	) bus (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_cyc(cyc),
		.i_dq(i_dq),
		.o_busy(bus_busy),
		.o_ack(bus_ack),
		.o_rdata(bus_rdata),
		.o_pins(o_flash)
	);

	// ready/busy pin synchroniser
	always_ff @(posedge i_clk) begin
		rdy_meta <= i_ready_busy_n_out;
		rdy_sync <= rdy_meta;
	end

	// axi write channel
	assign wr_fire = aw_held && w_held;
	assign ctrl_hit = wr_fire && (awaddr_q == REG_CTRL) && wstrb_q[0];
	assign go_start = ctrl_hit && wdata_q[CTRL_START] && state == S_IDLE && !bus_busy;
	assign go_reset = ctrl_hit && wdata_q[CTRL_RESET] && state == S_IDLE && !bus_busy && !wdata_q[CTRL_START];
	assign go_abort = ctrl_hit && wdata_q[CTRL_ABORT];

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			o_bvalid <= 1'b0;
			o_bresp <= AXI_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held <= 1'b1;
				awaddr_q <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_held <= 1'b1;
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (awaddr_q == REG_CTRL || awaddr_q == REG_ADDR || awaddr_q == REG_EXPECT ||
					awaddr_q == REG_STATUS || awaddr_q == REG_WORD) ? AXI_OKAY : AXI_SLVERR;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	// software-written settings
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			poll_addr <= '0;
			expect_word <= '0;
			mode_poll <= 1'b0;
		end else if (wr_fire) begin
			if (awaddr_q == REG_ADDR) begin
				poll_addr <= ADDR_W'(merge_strb(32'(poll_addr), wdata_q, wstrb_q));
			end
			if (awaddr_q == REG_EXPECT) begin
				expect_word <= DATA_W'(merge_strb(32'(expect_word), wdata_q, wstrb_q));
			end
			if (ctrl_hit && state == S_IDLE) begin
				mode_poll <= wdata_q[CTRL_MODE];
			end
		end
	end

	// axi read channel
	always_comb begin
		next_rdata = '0;
		next_rresp = AXI_OKAY;
		unique case (i_araddr)
			REG_CTRL: next_rdata[CTRL_MODE] = mode_poll;
			REG_ADDR: next_rdata = 32'(poll_addr);
			REG_EXPECT: next_rdata = 32'(expect_word);
			REG_STATUS: begin
				next_rdata[ST_BUSY] = (state != S_IDLE);
				next_rdata[ST_DONE] = done;
				next_rdata[ST_FAIL] = fail;
				next_rdata[ST_READY] = rdy_sync;
				next_rdata[ST_SECT_TOG] = sect_tog;
			end
			REG_WORD: next_rdata = 32'(last_word);
			default: next_rresp = AXI_SLVERR;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= AXI_OKAY;
		end else begin
			if (i_arvalid && o_arready) begin
				o_arready <= 1'b0;
				o_rvalid <= 1'b1;
				o_rdata <= next_rdata;
				o_rresp <= next_rresp;
			end
			if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
				o_arready <= 1'b1;
			end
		end
	end

	// polling decisions on each completed read
	assign toggled = bit_moved(prev_word, bus_rdata, ANY_ADDRESS_TOGGLE_BIT);
	assign poll_match = (bus_rdata[COMPLEMENT_POLL_BIT] == expect_word[COMPLEMENT_POLL_BIT]);
	assign limit_hit = bus_rdata[TIMING_LIMIT_FLAG];

	// every status read goes to the chosen address in the busy bank
	always_comb begin
		cyc.req = (state != S_IDLE);
		cyc.wr = (state == S_CMD_RESET);
		cyc.addr = poll_addr;
		cyc.data = RESET_CMD;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= S_IDLE;
			done <= 1'b0;
			fail <= 1'b0;
			sect_tog <= 1'b0;
			prev_word <= '0;
			last_word <= '0;
		end else if (go_abort) begin
			state <= S_IDLE;
		end else begin
			if (go_start) begin
				done <= 1'b0;
				fail <= 1'b0;
				state <= wdata_q[CTRL_MODE] ? S_P_READ : S_T_READ1;
			end
			if (go_reset) begin
				done <= 1'b0;
				state <= S_CMD_RESET;
			end
			if (bus_ack && state != S_IDLE) begin
				prev_word <= bus_rdata;
				unique case (state)
					S_T_READ1: state <= S_T_READ2;
					S_T_READ2: begin
						sect_tog <= bit_moved(prev_word, bus_rdata, SECTOR_TOGGLE_BIT);
						if (!toggled) begin
							state <= S_FINAL;
						end else if (limit_hit) begin
							state <= S_T_RECHECK;
						end
					end
					S_T_RECHECK: begin
						if (!toggled) begin
							state <= S_FINAL;
						end else begin
							fail <= 1'b1;
							state <= S_CMD_RESET;
						end
					end
					S_P_READ: begin
						if (poll_match) begin
							state <= S_FINAL;
						end else if (limit_hit) begin
							state <= S_P_RECHECK;
						end
					end
					S_P_RECHECK: begin
						if (poll_match) begin
							state <= S_FINAL;
						end else begin
							fail <= 1'b1;
							state <= S_CMD_RESET;
						end
					end
					S_FINAL: begin
						last_word <= bus_rdata;
						done <= 1'b1;
						state <= S_IDLE;
					end
					S_CMD_RESET: begin
						done <= 1'b1;
						state <= S_IDLE;
					end
					S_IDLE: state <= S_IDLE;
				endcase
			end
		end
	end

	// reads completed since the last start, for checking only
	always_ff @(posedge i_clk) begin
		if (i_reset || go_start) begin
			rd_cnt <= '0;
		end else if (bus_ack && !cyc.wr && rd_cnt != 2'h3) begin
			rd_cnt <= rd_cnt + 1'b1;
		end
	end

	status_addr_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(bus_ack && !o_flash.we_n == 1'b0 && state inside {S_T_READ1, S_T_READ2, S_P_READ})
		|-> o_flash.addr == poll_addr)
		else $error("status read not at the chosen address");
	reset_data_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(!o_flash.we_n && o_flash.dq_oe) |-> o_flash.dq_out == RESET_CMD)
		else $error("flash write other than the reset command");
	pair_done_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(state == S_FINAL && !mode_poll) |-> rd_cnt >= 2'h2)
		else $error("toggle completion before two reads");
	toggle_recheck_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(state == S_T_READ2 && bus_ack && toggled && limit_hit && !go_abort) |=> state == S_T_RECHECK)
		else $error("no recheck after limit flag while toggling");
	poll_recheck_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(state == S_P_READ && bus_ack && !poll_match && limit_hit && !go_abort) |=> state == S_P_RECHECK)
		else $error("no poll recheck after limit flag");
	fail_reset_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(state == S_T_RECHECK && bus_ack && toggled && !go_abort) |=> (state == S_CMD_RESET && fail)
		##[1:20] (!o_flash.we_n))
		else $error("failed operation not followed by reset write");
	restart_pair_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(go_start && !wdata_q[CTRL_MODE]) |=> state == S_T_READ1 && rd_cnt == 2'h0)
		else $error("toggle check not restarted from first read");
	final_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(state == S_P_READ && bus_ack && poll_match && !go_abort) |=> state == S_FINAL ##1 !done)
		else $error("completion reported without a following read");
	abort_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
		go_abort |=> state == S_IDLE && !cyc.req)
		else $error("abort did not leave monitoring");
endmodule : fwsr_ctrl

// ---- src/fwsr_pkg.sv ----
/*
 * Shared constants, carriers and state types for the flash status-polling controller.
 * Assumes a 50 MHz system clock and a 16-bit asynchronous NOR flash bus.
 */
package fwsr_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int AXI_AW = 8;
	localparam int CNT_W = 8;

	// own register map, one aligned word each
	localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] REG_ADDR = 8'h04;
	localparam logic [AXI_AW-1:0] REG_EXPECT = 8'h08;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h0c;
	localparam logic [AXI_AW-1:0] REG_WORD = 8'h10;

	// control bits
	localparam int CTRL_START = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_RESET = 2;
	localparam int CTRL_ABORT = 3;

	// status bits
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_READY = 3;
	localparam int ST_SECT_TOG = 4;

	// status bit positions on the data word lines
	localparam int COMPLEMENT_POLL_BIT = 7;
	localparam int ANY_ADDRESS_TOGGLE_BIT = 6;
	localparam int TIMING_LIMIT_FLAG = 5;
	localparam int SECTOR_TOGGLE_BIT = 2;

	localparam logic [DATA_W-1:0] RESET_CMD = 16'h00f0;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// bus timing
	localparam int CLK_NS = 20;
	localparam int ACCESS_NS = 70;
	localparam int WRITE_PULSE_NS = 35;
	localparam int SYNC_CYC = 2;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
	} fwsr_pins_s;

	typedef struct packed {
		logic req;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fwsr_cyc_s;

	typedef enum {BC_IDLE, BC_STROBE, BC_HOLD, BC_RECOVER} fwsr_bus_e;

	typedef enum {
		S_IDLE, S_T_READ1, S_T_READ2, S_T_RECHECK, S_P_READ, S_P_RECHECK, S_FINAL, S_CMD_RESET
	} fwsr_state_e;
endpackage : fwsr_pkg

// ---- src/fwsr_bus_cycle.sv ----
/*
 * One asynchronous flash bus cycle (read or write) per request, with synchronised read data.
 * Assumes the requester holds its request until the one-cycle acknowledge.
 */
`timescale 1ns/1ns
module fwsr_bus_cycle #(
	parameter int ACC_CYC = fwsr_pkg::ACCESS_CYC,
	parameter int WP_CYC = fwsr_pkg::WRITE_PULSE_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire fwsr_pkg::fwsr_cyc_s i_cyc,
	input wire logic [fwsr_pkg::DATA_W-1:0] i_dq,
	output logic o_busy,
	output logic o_ack,
	output logic [fwsr_pkg::DATA_W-1:0] o_rdata,
	output fwsr_pkg::fwsr_pins_s o_pins
);
	import fwsr_pkg::*;

	fwsr_bus_e state;
	logic [CNT_W-1:0] cnt;
	logic wr;
	logic [DATA_W-1:0] dq_meta;
	logic [DATA_W-1:0] dq_sync;

	// read strobe covers access time plus the synchroniser delay
	localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(ACC_CYC + SYNC_CYC - 1);
	localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WP_CYC - 1);

	assign o_busy = (state != BC_IDLE);

	always_ff @(posedge i_clk) begin
		dq_meta <= i_dq;
		dq_sync <= dq_meta;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= BC_IDLE;
			cnt <= '0;
			wr <= 1'b0;
			o_ack <= 1'b0;
			o_rdata <= '0;
			o_pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
		end else begin
			unique case (state)
				BC_IDLE: begin
					if (i_cyc.req) begin
						cnt <= '0;
						wr <= i_cyc.wr;
						o_pins.addr <= i_cyc.addr;
						o_pins.ce_n <= 1'b0;
						o_pins.oe_n <= i_cyc.wr;
						o_pins.we_n <= !i_cyc.wr;
						o_pins.dq_out <= i_cyc.data;
						o_pins.dq_oe <= i_cyc.wr;
						state <= BC_STROBE;
					end
				end
				BC_STROBE: begin
					cnt <= cnt + 1'b1;
					if (cnt == (wr ? WR_LAST : RD_LAST)) begin
						if (!wr) begin
							o_rdata <= dq_sync;
						end
						o_pins.oe_n <= 1'b1;
						o_pins.we_n <= 1'b1;
						state <= BC_HOLD;
					end
				end
				BC_HOLD: begin
					// data held past the write strobe's rising edge
					o_pins.ce_n <= 1'b1;
					o_pins.dq_oe <= 1'b0;
					o_ack <= 1'b1;
					state <= BC_RECOVER;
				end
				BC_RECOVER: begin
					o_ack <= 1'b0;
					state <= BC_IDLE;
				end
			endcase
		end
	end

	strobe_gap_a: assert property (@(posedge i_clk) disable iff (i_reset)
		o_ack |-> o_pins.ce_n && o_pins.oe_n && o_pins.we_n)
		else $error("bus strobes not released at acknowledge");
endmodule : fwsr_bus_cycle

// ---- verif/fwsr_flash_model.sv ----
/*
 * Behavioural flash device facing the status-polling controller: one bank, status on reads.
 * Assumes the bench starts an embedded operation with i_go; ready/busy has a pull-up.
 */
`timescale 1ns/1ns
module fwsr_flash_model (
	input wire fwsr_pkg::fwsr_pins_s i_flash,
	input wire logic i_go,
	input wire logic i_erase,
	input wire logic i_fail,
	input wire logic [fwsr_pkg::DATA_W-1:0] i_word,
	input wire logic [7:0] i_reads,
	output logic [fwsr_pkg::DATA_W-1:0] o_dq,
	output logic o_ready_busy_n_out,
	output logic o_reset_seen
);
	import fwsr_pkg::*;
	logic busy;
	logic tog;
	logic limit;
	logic [7:0] left;
	logic [DATA_W-1:0] last;
	logic [DATA_W-1:0] stat;
	initial begin
		busy = 1'b0;
		tog = 1'b0;
		limit = 1'b0;
		left = 8'h00;
		last = 16'h0000;
		o_reset_seen = 1'b0;
	end
	// status valid from the last rising edge of i_go
	always @(posedge i_go) begin
		busy = 1'b1;
		// toggle starts from a known level so expected pairs are fixed
		tog = 1'b0;
		left = i_reads;
		limit = 1'b0;
		o_reset_seen = 1'b0;
	end
	// each read strobe advances the operation; a short busy stands for protected targets
	always @(negedge i_flash.oe_n) begin
		if (!i_flash.ce_n && busy) begin
			tog = ~tog;
			if (left != 8'h00)
				left = left - 8'h01;
			else if (i_fail)
				limit = 1'b1;
			else
				busy = 1'b0;
		end
	end
	always @(posedge i_flash.we_n) begin
		if (!i_flash.ce_n && i_flash.dq_out == RESET_CMD) begin
			busy = 1'b0;
			limit = 1'b0;
			o_reset_seen = 1'b1;
		end
	end
	// taken from the driven word, not the bus, to avoid racing the release
	always @(posedge i_flash.oe_n) last = busy ? stat : i_word;
	always_comb begin
		stat = 16'h0000;
		stat[COMPLEMENT_POLL_BIT] = i_erase ? 1'b0 : ~i_word[COMPLEMENT_POLL_BIT];
		stat[ANY_ADDRESS_TOGGLE_BIT] = tog;
		stat[TIMING_LIMIT_FLAG] = limit;
		stat[SECTOR_TOGGLE_BIT] = tog & i_erase;
	end
	// released bus shows the inverse of the last word
	assign o_dq = (i_flash.oe_n || i_flash.ce_n) ? ~last : (busy ? stat : i_word);
	assign o_ready_busy_n_out = busy ? 1'b0 : 1'b1;
endmodule : fwsr_flash_model

// ---- verif/tb.sv ----
/*
 * Self-checking bench for the status-polling controller over AXI4-Lite.
 * Assumes the flash model file is compiled before this one.
 */
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
	$display("Error %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
	import fwsr_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, rb_n, go = 1'b0, erase = 1'b0, fl = 1'b0, rst_seen;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [15:0] dq, word = 16'h0;
	logic [7:0] reads = 8'h00;
	fwsr_pins_s flash;
	int fail_count = 0;
	int tests_run = 0;
	always #10 i_clk = ~i_clk;
	fwsr_ctrl dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_awvalid(awvalid), .o_awready(awready),
		.i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
		.o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
		.i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
		.o_flash(flash), .i_dq(dq), .i_ready_busy_n_out(rb_n));
	fwsr_flash_model flash_u (.i_flash(flash), .i_go(go), .i_erase(erase), .i_fail(fl), .i_word(word),
		.i_reads(reads), .o_dq(dq), .o_ready_busy_n_out(rb_n), .o_reset_seen(rst_seen));
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic timed_out();
		fail_count++;
		$display("Error %0t: wait ran out", $time);
		give_verdict();
	endtask : timed_out
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; bready <= 1'b1;
		while (n < 200) begin
			@(posedge i_clk);
			n++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n >= 200) timed_out();
		// one edge between transfers so bready is never set twice at once
		@(posedge i_clk);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		while (n < 200) begin
			@(posedge i_clk);
			n++;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				v = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n >= 200) timed_out();
		@(posedge i_clk);
	endtask : axi_rd
	// embedded operation in the model; fields: erase fail word reads
	task automatic start_model(input logic e, input logic f, input logic [15:0] w, input logic [7:0] n);
		erase <= e; fl <= f; word <= w; reads <= n; go <= 1'b1;
		@(posedge i_clk);
		go <= 1'b0;
	endtask : start_model
	// status reads until done, bounded
	task automatic wait_done();
		int k;
		k = 0;
		d = 32'h0;
		while (d[ST_DONE] !== 1'b1 && k < 300) begin
			axi_rd(REG_STATUS, d, r);
			k++;
		end
		if (k >= 300) timed_out();
	endtask : wait_done
	// one embedded operation, then one polling run; fields: mode erase fail word reads
	task automatic run_op(input logic m, input logic e, input logic f, input logic [15:0] w, input logic [7:0] n);
		start_model(e, f, w, n);
		repeat (SYNC_CYC + 1) @(posedge i_clk);
		axi_rd(REG_STATUS, d, r);
		`CHK(d[ST_READY], 1'b0)
		axi_wr(REG_EXPECT, {16'h0, w}, r);
		axi_wr(REG_ADDR, 32'h0000_1000, r);
		axi_wr(REG_CTRL, {30'h0, m, 1'b1}, r);
		`CHK(r, AXI_OKAY)
		wait_done();
		`CHK(d[ST_BUSY], 1'b0)
		`CHK(d[ST_FAIL], f)
		`CHK(rst_seen, f)
		`CHK(d[ST_READY], 1'b1)
		if (!f) begin
			axi_rd(REG_WORD, d, r);
			`CHK(d[15:0], w)
		end
	endtask : run_op
	initial begin
		repeat (10) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		axi_rd(REG_STATUS, d, r);
		`CHK(d[3:0], 4'b1000)
		axi_rd(8'h14, d, r);
		`CHK(r, AXI_SLVERR)
		axi_wr(8'h18, 32'h1, r);
		`CHK(r, AXI_SLVERR)
		axi_wr(REG_ADDR, 32'hffff_ffff, r);
		axi_rd(REG_ADDR, d, r);
		`CHK(d, 32'h003f_ffff)
		$display("test registers done");
		run_op(1'b0, 1'b0, 1'b0, 16'h1234, 8'h05);
		run_op(1'b1, 1'b0, 1'b0, 16'h00a5, 8'h03);
		run_op(1'b1, 1'b0, 1'b0, 16'h0012, 8'h04);
		run_op(1'b1, 1'b1, 1'b0, 16'hffff, 8'h06);
		run_op(1'b0, 1'b1, 1'b0, 16'hffff, 8'h02);
		axi_rd(REG_STATUS, d, r);
		`CHK(d[ST_SECT_TOG], 1'b1)
		$display("test completions done");
		run_op(1'b0, 1'b0, 1'b1, 16'h5555, 8'h02);
		run_op(1'b1, 1'b0, 1'b1, 16'h0080, 8'h02);
		$display("test failures done");
		// abort part-way, then restart from the first double read
		start_model(1'b0, 1'b0, 16'h1234, 8'h20);
		axi_wr(REG_CTRL, 32'h1, r);
		repeat (30) @(posedge i_clk);
		axi_wr(REG_CTRL, 32'h8, r);
		axi_rd(REG_STATUS, d, r);
		`CHK(d[ST_BUSY], 1'b0)
		`CHK(d[ST_DONE], 1'b0)
		repeat (10) @(posedge i_clk);
		axi_wr(REG_CTRL, 32'h1, r);
		wait_done();
		`CHK(d[ST_FAIL], 1'b0)
		axi_rd(REG_WORD, d, r);
		`CHK(d[15:0], 16'h1234)
		$display("test abort done");
		// reset command on its own ends a busy operation
		start_model(1'b0, 1'b0, 16'h0000, 8'h40);
		axi_wr(REG_CTRL, 32'h4, r);
		wait_done();
		`CHK(d[ST_FAIL], 1'b0)
		`CHK(rst_seen, 1'b1)
		`CHK(d[ST_READY], 1'b1)
		$display("test reset command done");
		give_verdict();
	end
endmodule : tb
